// file: core/pfc_defs.svh
// Timing and field constants for the parallel flash host controller
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
// ==========================================
// Clock
`define PFC_CLK_MHZ        50
// ==========================================
// Times in ns (least times, rounded up to cycles)
`define PFC_T_ACC_NS       90
`define PFC_T_WP_NS        35
`define PFC_T_SETUP_NS     20
`define PFC_T_RP_NS        500
`define PFC_T_RH_NS        50
// Longest time the flash may stay busy after reset, in ns
`define PFC_T_READY_NS     20000
// Protect or unprotect strobe width, in us
`define PFC_T_HV_PULSE_US  100
// ==========================================
// Cycle counts derived from the times
`define PFC_CYC_UP(ns)     (((ns) * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_ACC_CYC        `PFC_CYC_UP(`PFC_T_ACC_NS)
`define PFC_WP_CYC         `PFC_CYC_UP(`PFC_T_WP_NS)
`define PFC_SETUP_CYC      `PFC_CYC_UP(`PFC_T_SETUP_NS)
`define PFC_RP_CYC         `PFC_CYC_UP(`PFC_T_RP_NS)
`define PFC_RH_CYC         `PFC_CYC_UP(`PFC_T_RH_NS)
`define PFC_READY_CYC      `PFC_CYC_UP(`PFC_T_READY_NS)
`define PFC_HV_PULSE_CYC   (`PFC_T_HV_PULSE_US * `PFC_CLK_MHZ)
// Extra cycles a read waits for the data synchroniser
`define PFC_SYNC_CYC       2
// ==========================================
// Address field positions
`define PFC_A1_BIT         1
`define PFC_A6_BIT         6
`define PFC_ADDR_W         22
`define PFC_DATA_W         8
// Protected verify code bit
`define PFC_PROT_BIT       0
`endif

// file: core/pfc_host.sv
// Host controller that drives an asynchronous byte-wide flash through its pins
// Behaviour
// R1 - Verify answers 00h unprotected, 01h protected
// R2 - Read: select and gate low, strobe high
// R3 - After reset, plain reads give array data
// R4 - Array read holds until a command write
// R5 - Write: strobe and select low, gate high
// R6 - Bad sequences return flash to array read
// R7 - Auto-select codes read with normal timing
// R8 - Accel level only during accelerated programming
// R9 - Standby floats outputs regardless of gate
// R10 - No recovery delay after reset standby (host waits PFC_RH_CYC after a reset pulse)
// R11 - Flash self-standbys on stable address
// R12 - Gate high floats flash data outputs
// R13 - Reset pulse at least minimum width
// R14 - Host reissues operation interrupted by reset (host only returns busy_seen in rsp_data bit 0)
// R15 - Flash busy after reset, bounded wait
// R16 - Wait recovery delay before first read
// R17 - Protected groups refuse program and erase
// R18 - Protect: high level, A6 low, strobe pulse
// R19 - Hardware verify: A1 high, Q0 flags protect
// R20 - In-system verify via identification command
// R21 - Unprotect: high level, A6 high, strobe pulse
// R22 - High level on reset lifts protection
// R23 - Address on later fall, data earlier rise
`timescale 1ns/10ps
`default_nettype none
`include "pfc_defs.svh"

module pfc_host #(
    parameter int HV_PULSE_CYC = `PFC_HV_PULSE_CYC  // Protect strobe width
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    // User command port
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire logic [2:0]               cmd_op,
    input  wire logic [`PFC_ADDR_W-1:0]   cmd_addr,
    input  wire logic [`PFC_DATA_W-1:0]   cmd_data,
    input  wire logic                     cmd_accel,
    input  wire logic                     temp_unprotect,
    output logic                          rsp_valid,
    output logic [`PFC_DATA_W-1:0]        rsp_data,
    output logic                          rsp_protected,
    // Flash pins
    output logic [`PFC_ADDR_W-1:0]        flash_addr,
    output logic                          chip_select_n,
    output logic                          output_gate_n,
    output logic                          write_strobe_n,
    output logic                          hard_reset_n,
    input  wire logic [`PFC_DATA_W-1:0]   dq_in,
    output logic [`PFC_DATA_W-1:0]        dq_out,
    output logic                          dq_oe,
    input  wire logic                     ready_busy_n,
    output logic                          hv_id_line_en,
    output logic                          hv_gate_en,
    output logic                          hv_reset_en,
    output logic                          accel_en
);
    // ==========================================
    // State
    pfc_pkg::pfc_state_t      state;        // Sequencer state
    pfc_pkg::pfc_state_t      next_state;
    logic [15:0]              cnt;          // Phase timer
    logic [15:0]              next_cnt;
    logic                     busy_seen;    // Flash went busy after reset
    logic                     next_busy_seen;
    logic                     is_verify;    // Current read is a verify
    logic                     next_is_verify;
    logic                     next_rsp_valid;
    logic [`PFC_DATA_W-1:0]   next_rsp_data;
    logic                     next_rsp_protected;
    logic [`PFC_ADDR_W-1:0]   next_flash_addr;
    logic [`PFC_DATA_W-1:0]   next_dq_out;
    logic                     next_cs_n;
    logic                     next_oe_n;
    logic                     next_we_n;
    logic                     next_rst_n;
    logic                     next_dq_oe;
    logic                     next_hv_id;
    logic                     next_hv_gate;
    logic                     next_accel;
    // Pin synchronisers
    logic [`PFC_DATA_W-1:0]   dq_s1;        // First stage, read by dq_s2 only
    logic [`PFC_DATA_W-1:0]   dq_s2;
    logic                     rb_s1;        // First stage, read by rb_s2 only
    logic                     rb_s2;
    logic                     temp_s;       // Registered unprotect level

    // Idle-only acceptance keeps one operation on the pins at a time
    assign cmd_ready = (state == pfc_pkg::PFC_IDLE);

    // ==========================================
    // Synchronise flash-driven pins and the unprotect level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            rb_s1 <= 1'b1;
            rb_s2 <= 1'b1;
            temp_s <= 1'b0;
            hv_reset_en <= 1'b0;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            rb_s1 <= ready_busy_n;
            rb_s2 <= rb_s1;
            temp_s <= temp_unprotect;
            // Level on reset drops one cycle after the reset pin falls and returns one cycle after it rises
            hv_reset_en <= temp_s && (state != pfc_pkg::PFC_RST_LOW); // R22
        end
    end

    // ==========================================
    // Next-value logic for the sequencer and pins
    always_comb begin
        next_state = state;
        next_cnt = (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
        next_busy_seen = busy_seen;
        next_is_verify = is_verify;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_protected = rsp_protected;
        next_flash_addr = flash_addr;
        next_dq_out = dq_out;
        next_cs_n = chip_select_n;
        next_oe_n = output_gate_n;
        next_we_n = write_strobe_n;
        next_rst_n = hard_reset_n;
        next_dq_oe = dq_oe;
        next_hv_id = hv_id_line_en;
        next_hv_gate = hv_gate_en;
        next_accel = accel_en;
        case (state)
            pfc_pkg::PFC_IDLE: begin
                // Park everything deselected; stable address lets flash idle
                next_cs_n = 1'b1; // R9 R11
                next_oe_n = 1'b1; // R12
                next_we_n = 1'b1;
                next_dq_oe = 1'b0;
                if (cmd_valid) begin
                    next_flash_addr = cmd_addr;
                    next_dq_out = cmd_data;
                    case (cmd_op)
                        3'h0, 3'h3: begin
                            // Read or verify: select and gate, strobe high
                            next_is_verify = (cmd_op == 3'h3);
                            next_hv_id = (cmd_op == 3'h3); // R19
                            if (cmd_op == 3'h3) begin
                                next_flash_addr[`PFC_A1_BIT] = 1'b1; // R19
                            end
                            next_cs_n = 1'b0; // R2
                            next_oe_n = 1'b0; // R2
                            next_cnt = 16'(`PFC_ACC_CYC + `PFC_SYNC_CYC); // R7
                            next_state = pfc_pkg::PFC_RD_WAIT;
                        end
                        3'h1: begin
                            // Command or program byte; address set before strobes
                            next_cs_n = 1'b0; // R5
                            next_dq_oe = 1'b1;
                            next_accel = cmd_accel; // R8
                            next_cnt = 16'(`PFC_SETUP_CYC);
                            next_state = pfc_pkg::PFC_WR_SETUP;
                        end
                        3'h2: begin
                            next_rst_n = 1'b0; // R13
                            next_busy_seen = 1'b0;
                            next_cnt = 16'(`PFC_RP_CYC);
                            next_state = pfc_pkg::PFC_RST_LOW;
                        end
                        3'h4, 3'h5: begin
                            // High level on id line and gate, A6 picks the action
                            next_flash_addr[`PFC_A6_BIT] = (cmd_op == 3'h5); // R18 R21
                            next_cs_n = 1'b0;
                            next_hv_id = 1'b1;
                            next_hv_gate = 1'b1;
                            next_cnt = 16'(`PFC_SETUP_CYC);
                            next_state = pfc_pkg::PFC_HV_SETUP;
                        end
                        default: begin
                            // Unknown code is answered at once and only loads the address and data registers
                            next_rsp_valid = 1'b1;
                        end
                    endcase
                end
            end
            pfc_pkg::PFC_RD_WAIT: begin
                if (cnt == 16'h0000) begin
                    next_rsp_data = dq_s2; // R3 R4
                    next_rsp_protected = is_verify && dq_s2[`PFC_PROT_BIT]; // R1 R20
                    next_rsp_valid = 1'b1;
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_hv_id = 1'b0;
                    next_state = pfc_pkg::PFC_IDLE;
                end
            end
            pfc_pkg::PFC_WR_SETUP: begin
                if (cnt == 16'h0000) begin
                    next_we_n = 1'b0; // R23
                    next_cnt = 16'(`PFC_WP_CYC);
                    next_state = pfc_pkg::PFC_WR_PULSE;
                end
            end
            pfc_pkg::PFC_WR_PULSE: begin
                if (cnt == 16'h0000) begin
                    // Strobe rises first so data is taken while still driven
                    next_we_n = 1'b1; // R23
                    next_state = pfc_pkg::PFC_WR_HOLD;
                end
            end
            pfc_pkg::PFC_WR_HOLD: begin
                next_cs_n = 1'b1;
                next_dq_oe = 1'b0;
                next_accel = 1'b0; // R8
                next_rsp_valid = 1'b1;
                next_state = pfc_pkg::PFC_IDLE;
            end
            pfc_pkg::PFC_RST_LOW: begin
                if (cnt == 16'h0000) begin
                    next_rst_n = 1'b1;
                    next_cnt = 16'(`PFC_READY_CYC);
                    next_state = pfc_pkg::PFC_RST_BUSY;
                end
            end
            pfc_pkg::PFC_RST_BUSY: begin
                // Flash may hold busy while its algorithm unwinds
                if (!rb_s2) begin
                    next_busy_seen = 1'b1;
                end
                if (rb_s2 || cnt == 16'h0000) begin // R15
                    next_cnt = 16'(`PFC_RH_CYC);
                    next_state = pfc_pkg::PFC_RST_RECOVER;
                end
            end
            pfc_pkg::PFC_RST_RECOVER: begin
                if (cnt == 16'h0000) begin // R16
                    // Busy flag tells the user an operation was cut short
                    next_rsp_data = {7'h00, busy_seen}; // R14
                    next_rsp_valid = 1'b1;
                    next_state = pfc_pkg::PFC_IDLE;
                end
            end
            pfc_pkg::PFC_HV_SETUP: begin
                if (cnt == 16'h0000) begin
                    next_we_n = 1'b0; // R18 R21
                    next_cnt = 16'(HV_PULSE_CYC);
                    next_state = pfc_pkg::PFC_HV_PULSE;
                end
            end
            pfc_pkg::PFC_HV_PULSE: begin
                if (cnt == 16'h0000) begin
                    next_we_n = 1'b1;
                    next_state = pfc_pkg::PFC_HV_HOLD;
                end
            end
            pfc_pkg::PFC_HV_HOLD: begin
                next_cs_n = 1'b1;
                next_hv_id = 1'b0;
                next_hv_gate = 1'b0;
                next_rsp_valid = 1'b1;
                next_state = pfc_pkg::PFC_IDLE;
            end
            default: begin
                next_state = pfc_pkg::PFC_IDLE;
            end
        endcase
    end

    // ==========================================
    // Register the sequencer and pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= pfc_pkg::PFC_IDLE;
            cnt <= 16'h0000;
            busy_seen <= 1'b0;
            is_verify <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_protected <= 1'b0;
            flash_addr <= 22'h000000;
            dq_out <= 8'h00;
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            hard_reset_n <= 1'b1;
            dq_oe <= 1'b0;
            hv_id_line_en <= 1'b0;
            hv_gate_en <= 1'b0;
            accel_en <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            busy_seen <= next_busy_seen;
            is_verify <= next_is_verify;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_protected <= next_rsp_protected;
            flash_addr <= next_flash_addr;
            dq_out <= next_dq_out;
            chip_select_n <= next_cs_n;
            output_gate_n <= next_oe_n;
            write_strobe_n <= next_we_n;
            hard_reset_n <= next_rst_n;
            dq_oe <= next_dq_oe;
            hv_id_line_en <= next_hv_id;
            hv_gate_en <= next_hv_gate;
            accel_en <= next_accel;
        end
    end
endmodule

`default_nettype wire

// file: core/pfc_pkg.sv
// Types shared by the parallel flash host controller
package pfc_pkg;
    // ==========================================
    // Operations a user may request
    typedef enum logic [2:0] {
        PFC_OP_READ,
        PFC_OP_WRITE,
        PFC_OP_RESET,
        PFC_OP_VERIFY,
        PFC_OP_PROTECT,
        PFC_OP_UNPROTECT
    } pfc_op_t;
    // Controller states
    typedef enum logic [3:0] {
        PFC_IDLE,
        PFC_RD_WAIT,
        PFC_WR_SETUP,
        PFC_WR_PULSE,
        PFC_WR_HOLD,
        PFC_RST_LOW,
        PFC_RST_BUSY,
        PFC_RST_RECOVER,
        PFC_HV_SETUP,
        PFC_HV_PULSE,
        PFC_HV_HOLD
    } pfc_state_t;
endpackage

// file: test/parallel_flash_bus_and_protect_control_test.sv
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
`default_nettype none
`include "pfc_defs.svh"
module parallel_flash_bus_and_protect_control_test;
    localparam logic [7:0] ID_CODE = 8'h5E;  // Arbitrary identification value
    logic clk, rst, cmd_valid, cmd_ready, cmd_accel, temp_unprotect, rsp_valid, rsp_protected, p;
    logic chip_select_n, output_gate_n, write_strobe_n, hard_reset_n, dq_oe, ready_busy_n;
    logic hv_id_line_en, hv_gate_en, hv_reset_en, accel_en;
    logic [2:0] cmd_op;
    logic [`PFC_ADDR_W-1:0] cmd_addr, flash_addr;
    logic [7:0] cmd_data, rsp_data, dq_in, dq_out, r;
    int n_errors, samples_checked;
    pfc_host #(.HV_PULSE_CYC(20)) dut_u (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
        .cmd_data, .cmd_accel, .temp_unprotect, .rsp_valid, .rsp_data, .rsp_protected, .flash_addr,
        .chip_select_n, .output_gate_n, .write_strobe_n, .hard_reset_n, .dq_in, .dq_out, .dq_oe,
        .ready_busy_n, .hv_id_line_en, .hv_gate_en, .hv_reset_en, .accel_en);
    pfc_flash_model #(.ID_CODE(ID_CODE)) model_u (.flash_addr, .chip_select_n, .output_gate_n,
        .write_strobe_n, .hard_reset_n, .dq_out, .hv_id_line_en, .hv_gate_en, .hv_reset_en,
        .accel_en, .dq_in, .ready_busy_n);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================
    // Verdict and end of run
    task results;
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, answer awaited under a bound
    task automatic op(input logic [2:0] o, input logic [21:0] a, input logic [7:0] d, input logic acc);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_accel <= acc;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 2000) begin
            n_errors++;
            $display("ERROR %0t no answer", $time);
            results();
        end
        r = rsp_data;
        p = rsp_protected;
    endtask
    task wr(input logic [21:0] a, input logic [7:0] d); op(3'h1, a, d, 1'b0); endtask
    task rd(input logic [21:0] a, input logic [7:0] e); op(3'h0, a, 8'h00, 1'b0); chk(r, e); endtask
    task unlock(input logic [7:0] c); wr(0, 8'hAA); wr(0, 8'h55); wr(0, c); endtask
    task prog(input logic [21:0] a, input logic [7:0] d, input logic acc);
        unlock(8'hA0);
        op(3'h1, a, d, acc);
    endtask
    // ==========================================
    // Scenarios
    task s_power_read;
        rd(22'h000010, 8'h10 ^ 8'h5A);
        op(3'h6, 22'h0, 8'h00, 1'b0);
        rd(22'h000011, 8'h11 ^ 8'h5A);
    endtask
    task s_program;
        prog(22'h000021, 8'h3C, 1'b1);
        rd(22'h000021, 8'h3C);
        rd(22'h000022, 8'h22 ^ 8'h5A);
    endtask
    task s_bad_sequence;
        wr(0, 8'hAA);
        wr(0, 8'h12);
        wr(0, 8'hA0);
        wr(22'h000040, 8'h77);
        rd(22'h000040, 8'h40 ^ 8'h5A);
        unlock(8'h90);
        rd(22'h000000, ID_CODE);
        rd(22'h000002, 8'h00);
        wr(0, 8'hF0);
        rd(22'h000000, 8'h5A);
    endtask
    task s_protect;
        op(3'h4, 22'h010000, 8'h00, 1'b0);
        op(3'h3, 22'h010000, 8'h00, 1'b0);
        chk(r, 8'h01);
        chk({7'h0, p}, 8'h01);
        op(3'h3, 22'h000000, 8'h00, 1'b0);
        chk(r, 8'h00);
        prog(22'h010005, 8'hC3, 1'b0);
        rd(22'h010005, 8'h05 ^ 8'h5A);
        @(posedge clk);
        temp_unprotect <= 1'b1;
        prog(22'h010005, 8'hC3, 1'b0);
        rd(22'h010005, 8'hC3);
        @(posedge clk);
        temp_unprotect <= 1'b0;
        prog(22'h010006, 8'hE1, 1'b0);
        rd(22'h010006, 8'h06 ^ 8'h5A);
        unlock(8'h90);
        rd(22'h010002, 8'h01);
        wr(0, 8'hF0);
        op(3'h5, 22'h000040, 8'h00, 1'b0);
        op(3'h3, 22'h010000, 8'h00, 1'b0);
        chk(r, 8'h00);
    endtask
    task s_hw_reset;
        prog(22'h000030, 8'h11, 1'b0);
        op(3'h2, 22'h0, 8'h00, 1'b0);
        chk(r, 8'h01);
        prog(22'h000030, 8'h11, 1'b0);
        rd(22'h000030, 8'h11);
        unlock(8'h90);
        rd(22'h000000, ID_CODE);
        op(3'h2, 22'h0, 8'h00, 1'b0);
        chk(r, 8'h00);
        rd(22'h000000, 8'h5A);
    endtask
    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        cmd_addr = '0;
        cmd_data = 8'h00;
        cmd_accel = 1'b0;
        temp_unprotect = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        s_power_read();
        s_program();
        s_bad_sequence();
        s_protect();
        s_hw_reset();
        results();
    end
endmodule
`default_nettype wire

// file: test/pfc_flash_model.sv
// Behavioural byte-wide flash as seen at its pins
`timescale 1ns/10ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h5E  // Arbitrary identification value
) (
    input  wire logic [`PFC_ADDR_W-1:0] flash_addr,
    input  wire logic                   chip_select_n,
    input  wire logic                   output_gate_n,
    input  wire logic                   write_strobe_n,
    input  wire logic                   hard_reset_n,
    input  wire logic [`PFC_DATA_W-1:0] dq_out,
    input  wire logic                   hv_id_line_en,
    input  wire logic                   hv_gate_en,
    input  wire logic                   hv_reset_en,
    input  wire logic                   accel_en,
    output logic      [`PFC_DATA_W-1:0] dq_in,
    output logic                        ready_busy_n
);
    logic [7:0]  mem [256];  // Low address byte only, keeps the model small
    logic [63:0] prot;       // One protect flag per group
    logic [7:0]  rd_val;     // Value a read would return
    logic [7:0]  hold;       // Last driven value
    logic [21:0] wa;         // Latched write address
    logic [1:0]  step;       // Unlock sequence position
    logic        autosel;    // Identification mode
    realtime     busy_end;   // Busy lasts until this time
    // ==========================================
    // Power-up: array read, nothing protected
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        prot = '0;
        step = 2'h0;
        autosel = 1'b0;
        busy_end = 0;
        hold = 8'h00;
    end
    // Busy flag follows the end time
    always #5 ready_busy_n = ($realtime >= busy_end);
    // Reset pin aborts and keeps busy until internal reset ends
    always @(negedge hard_reset_n) begin
        step = 2'h0;
        autosel = 1'b0;
        if (!ready_busy_n) busy_end = $realtime + 1500;
    end
    // Read source select; no recovery delay and no self-standby effect on data
    always @(*) begin
        if ((hv_id_line_en || autosel) && flash_addr[1]) rd_val = {7'h0, prot[flash_addr[21:16]]};
        else if (hv_id_line_en || autosel) rd_val = ID_CODE;
        else rd_val = mem[flash_addr[7:0]];
    end
    // Released lines show the inverse of the last value, never a lucky match
    always @(*) begin
        if (!chip_select_n && !output_gate_n && write_strobe_n && hard_reset_n) begin
            dq_in = rd_val;
            hold = rd_val;
        end else dq_in = ~hold;
    end
    // Address on the later falling edge
    always @(negedge write_strobe_n) if (!chip_select_n) wa = flash_addr;
    // Data on the earlier rising edge
    always @(posedge write_strobe_n) begin
        if (hard_reset_n && !chip_select_n && hv_gate_en && hv_id_line_en) begin
            if (wa[6]) prot = '0;
            else prot[wa[21:16]] = 1'b1;
        end else if (hard_reset_n && !chip_select_n && output_gate_n) begin
            if (step == 2'h3) begin
                if (!prot[wa[21:16]] || hv_reset_en) mem[wa[7:0]] = dq_out;
                busy_end = $realtime + (accel_en ? 300 : 600);
                step = 2'h0;
            end else if (step == 2'h0 && dq_out == 8'hAA) step = 2'h1;
            else if (step == 2'h1 && dq_out == 8'h55) step = 2'h2;
            else if (step == 2'h2 && dq_out == 8'hA0) step = 2'h3;
            else if (step == 2'h2 && dq_out == 8'h90) begin
                step = 2'h0;
                autosel = 1'b1;
            end else begin
                step = 2'h0;
                autosel = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/pfc_host_checker.sv
// Pin-level assertions for the flash host controller
`timescale 1ns/10ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_host_checker #(
    parameter int HV_PULSE_CYC = `PFC_HV_PULSE_CYC  // Protect strobe width in cycles
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   cmd_valid,
    input wire logic                   cmd_ready,
    input wire logic [2:0]             cmd_op,
    input wire logic                   rsp_valid,
    input wire logic [`PFC_ADDR_W-1:0] flash_addr,
    input wire logic                   chip_select_n,
    input wire logic                   output_gate_n,
    input wire logic                   write_strobe_n,
    input wire logic                   hard_reset_n,
    input wire logic [`PFC_DATA_W-1:0] dq_out,
    input wire logic                   dq_oe,
    input wire logic                   hv_id_line_en,
    input wire logic                   hv_gate_en,
    input wire logic                   accel_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Low-time counters; long pulses cannot be written as repetitions
    logic [15:0] wl_cnt;  // Strobe low cycles so far
    logic [7:0]  rl_cnt;  // Reset pin low cycles so far
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wl_cnt <= 16'h0;
            rl_cnt <= 8'h0;
        end else begin
            wl_cnt <= write_strobe_n ? 16'h0 : wl_cnt + 16'h1;
            rl_cnt <= hard_reset_n ? 8'h0 : rl_cnt + 8'h1;
        end
    end
    // ==========================================
    // Properties
    property p_read_qual;
        (!chip_select_n && !output_gate_n) |-> write_strobe_n && !dq_oe;
    endproperty
    a_read_qual: assert property (p_read_qual) else $error("read with strobe or drive");
    property p_write_qual;
        !write_strobe_n |-> !chip_select_n && (output_gate_n || hv_gate_en);
    endproperty
    a_write_qual: assert property (p_write_qual) else $error("bad write qualifiers");
    property p_read_walk;
        (cmd_valid && cmd_ready && cmd_op == 3'h0)
            |=> (!chip_select_n && !output_gate_n) [*8] ##1 rsp_valid;
    endproperty
    a_read_walk: assert property (p_read_walk) else $error("read cycle timing");
    property p_write_walk;
        (cmd_valid && cmd_ready && cmd_op == 3'h1) |-> ##3 (!write_strobe_n) [*3]
            ##1 (write_strobe_n && !chip_select_n) ##1 rsp_valid;
    endproperty
    a_write_walk: assert property (p_write_walk) else $error("write cycle timing");
    property p_latch_stable;
        !write_strobe_n |-> $stable(flash_addr) && $stable(dq_out);
    endproperty
    a_latch_stable: assert property (p_latch_stable) else $error("addr or data moved");
    property p_accel;
        accel_en |-> dq_oe && !hv_gate_en;
    endproperty
    a_accel: assert property (p_accel) else $error("accel outside a write");
    property p_gate_free;
        dq_oe |-> output_gate_n;
    endproperty
    a_gate_free: assert property (p_gate_free) else $error("drive while gate low");
    property p_reset_width;
        $rose(hard_reset_n) |-> rl_cnt == 8'(`PFC_RP_CYC + 1);
    endproperty
    a_reset_width: assert property (p_reset_width) else $error("reset pulse width");
    property p_protect_width;
        ($rose(write_strobe_n) && hv_gate_en) |-> wl_cnt >= 16'(HV_PULSE_CYC);
    endproperty
    a_protect_width: assert property (p_protect_width) else $error("protect pulse short");
    property p_verify_a1;
        (hv_id_line_en && !output_gate_n) |-> flash_addr[1];
    endproperty
    a_verify_a1: assert property (p_verify_a1) else $error("verify with A1 low");
    property p_hv_setup;
        hv_gate_en |-> hv_id_line_en && !chip_select_n;
    endproperty
    a_hv_setup: assert property (p_hv_setup) else $error("high level set wrongly");
endmodule
bind pfc_host pfc_host_checker #(.HV_PULSE_CYC(HV_PULSE_CYC)) chk_u (.clk, .rst, .cmd_valid,
    .cmd_ready, .cmd_op, .rsp_valid, .flash_addr, .chip_select_n, .output_gate_n,
    .write_strobe_n, .hard_reset_n, .dq_out, .dq_oe, .hv_id_line_en, .hv_gate_en, .accel_en);
`default_nettype wire
